/* dual_input_map.vh */
// register offsets, reset values and timing counts of the dual input module
`ifndef DUAL_INPUT_MAP_VH
`define DUAL_INPUT_MAP_VH
`define REG_INPUT_IMAGE         3'h0
`define REG_DIAG_INTERRUPT_ENABLE             3'h1
`define REG_FILTER_CH0          3'h2
`define REG_FILTER_CH1          3'h3
`define REG_RISE_EN             3'h4
`define REG_FALL_EN             3'h5
`define REG_IRQ_DATA            3'h6
`define REG_IRQ_STATE           3'h7
`define RST_DIAG_INTERRUPT_ENABLE             8'h00
`define RST_FILTER              8'h02
`define RST_EDGE_EN             8'h00
`define DIAG_INTERRUPT_ENABLE_OFF             8'h00
`define DIAG_INTERRUPT_ENABLE_ON              8'h40
`define DLY_CODE_1US            8'h00
`define DLY_CODE_3US            8'h02
`define DLY_CODE_10US           8'h04
`define DLY_CODE_86US           8'h07
`define DLY_CODE_342US          8'h09
`define DLY_CODE_2731US         8'h0C
`define CLK_MHZ                 100
`define DLY_US_1                1
`define DLY_US_3                3
`define DLY_US_10               10
`define DLY_US_86               86
`define DLY_US_342              342
`define DLY_US_2731             2731
`define BLINK_HZ                2
`define CLK_HZ                  100000000
`define BLINK_HALF_CYCLES       (`CLK_HZ / (2 * `BLINK_HZ))
`endif

/* input_filter.v */
// per-channel input filter with selectable delay for both edges
`timescale 1ns/100ps
`include "dual_input_map.vh"
module input_filter #(
	parameter CNT_W = 19
) (
	input  wire             sys_clk_i,
	input  wire             rst_i,
	input  wire             raw_i,
	input  wire [7:0]       code_i,
	output reg              filt_o,
	output reg              bad_code_o
);
	reg [CNT_W-1:0] cnt_q;
	// kept at the width of the delay constants so no count is cut
	reg [31:0]      limit;

	// delay code to cycle count, other codes flagged
	always @*
	begin
		bad_code_o = 1'b0;
		case (code_i)
			`DLY_CODE_1US:    limit = `DLY_US_1 * `CLK_MHZ;
			`DLY_CODE_3US:    limit = `DLY_US_3 * `CLK_MHZ;
			`DLY_CODE_10US:   limit = `DLY_US_10 * `CLK_MHZ;
			`DLY_CODE_86US:   limit = `DLY_US_86 * `CLK_MHZ;
			`DLY_CODE_342US:  limit = `DLY_US_342 * `CLK_MHZ;
			`DLY_CODE_2731US: limit = `DLY_US_2731 * `CLK_MHZ;
			default:
			begin
				limit = `DLY_US_3 * `CLK_MHZ;
				bad_code_o = 1'b1;
			end
		endcase
	end

	// output follows input once it has differed for limit cycles
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= {CNT_W{1'b0}};
			filt_o <= 1'b0;
		end
		else if (raw_i == filt_o)
			cnt_q <= {CNT_W{1'b0}};
		else if (cnt_q >= limit - 1'b1)
		begin
			cnt_q  <= {CNT_W{1'b0}};
			filt_o <= raw_i;
		end
		else
			cnt_q <= cnt_q + 1'b1;
	end
endmodule

/* blink_gen.v */
// square wave for the configuration error indication
`timescale 1ns/100ps
`include "dual_input_map.vh"
module blink_gen #(
	parameter HALF = `BLINK_HALF_CYCLES
) (
	input  wire             sys_clk_i,
	input  wire             rst_i,
	output reg              blink_o
);
	reg [31:0] cnt_q;

	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			cnt_q   <= 32'h00000000;
			blink_o <= 1'b0;
		end
		else if (cnt_q >= HALF - 1)
		begin
			cnt_q   <= 32'h00000000;
			blink_o <= ~blink_o;
		end
		else
			cnt_q <= cnt_q + 32'h00000001;
	end
endmodule

/* dual_input_filter_irq_module.v */
// two-channel filtered digital input with edge interrupts and status indicators
`timescale 1ns/100ps
`include "dual_input_map.vh"
module dual_input_filter_irq_module #(
	parameter BLINK_HALF = `BLINK_HALF_CYCLES
) (
	input  wire             sys_clk_i,
	input  wire             rst_i,
	input  wire             input_ch0_i,
	input  wire             input_ch1_i,
	input  wire             bus_ok_i,
	input  wire             bus_power_ok_i,
	input  wire             module_error_i,
	input  wire             stop_state_i,
	input  wire             cfg_wr_i,
	input  wire [2:0]       cfg_addr_i,
	input  wire [7:0]       cfg_wdata_i,
	input  wire             cfg_rd_i,
	input  wire             out_wr_i,
	input  wire [7:0]       out_wdata_i,
	input  wire             irq_ack_i,
	output reg  [7:0]       cfg_rdata_o,
	output reg  [7:0]       input_image_o,
	output reg              proc_irq_o,
	output reg              diag_irq_o,
	output reg              irq_lost_o,
	output reg              run_led_o,
	output reg              fault_led_o,
	output reg  [1:0]       ch_led_o,
	output reg              cfg_error_o
);
	reg  [7:0] diag_interrupt_enable_q;
	reg  [7:0] filter_ch0_q;
	reg  [7:0] filter_ch1_q;
	reg  [7:0] rise_en_q;
	reg  [7:0] fall_en_q;
	reg  [1:0] prev_q;
	reg  [1:0] irq_edges_q;
	reg  [1:0] irq_state_q;
	reg        pending_q;
	reg        lost_q;
	reg        diag_bad_q;
	wire [1:0] raw;
	wire [1:0] filt;
	wire [1:0] bad_code;
	wire [1:0] rise;
	wire [1:0] fall;
	wire [1:0] edges;
	wire       diag_on;
	wire       cfg_err;
	wire       blink;
	wire [7:0] out_unused;

	assign raw = {input_ch1_i, input_ch0_i};
	// output area is not used; data is dropped
	assign out_unused = out_wr_i ? out_wdata_i : 8'h00;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : ch
			input_filter u_filter (
				.sys_clk_i  (sys_clk_i),
				.rst_i      (rst_i),
				.raw_i      (raw[g]),
				.code_i     (g == 0 ? filter_ch0_q : filter_ch1_q),
				.filt_o     (filt[g]),
				.bad_code_o (bad_code[g])
			);
		end
	endgenerate

	blink_gen #(
		.HALF (BLINK_HALF)
	) u_blink (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.blink_o   (blink)
	);

	assign rise    = filt & ~prev_q & rise_en_q[1:0];
	assign fall    = ~filt & prev_q & fall_en_q[1:0];
	assign edges   = rise | fall;
	assign diag_on = (diag_interrupt_enable_q == `DIAG_INTERRUPT_ENABLE_ON);
	assign cfg_err = |bad_code | diag_bad_q;

	// configuration registers
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			diag_interrupt_enable_q    <= `RST_DIAG_INTERRUPT_ENABLE;
			filter_ch0_q <= `RST_FILTER;
			filter_ch1_q <= `RST_FILTER;
			rise_en_q    <= `RST_EDGE_EN;
			fall_en_q    <= `RST_EDGE_EN;
			diag_bad_q   <= 1'b0;
		end
		else if (cfg_wr_i)
		begin
			case (cfg_addr_i)
				`REG_DIAG_INTERRUPT_ENABLE:
				begin
					// diag enable only accepted in stop state
					if (stop_state_i)
					begin
						diag_interrupt_enable_q  <= cfg_wdata_i;
						diag_bad_q <= (cfg_wdata_i != `DIAG_INTERRUPT_ENABLE_OFF) &&
							(cfg_wdata_i != `DIAG_INTERRUPT_ENABLE_ON);
					end
				end
				`REG_FILTER_CH0: filter_ch0_q <= cfg_wdata_i;
				`REG_FILTER_CH1: filter_ch1_q <= cfg_wdata_i;
				`REG_RISE_EN:    rise_en_q    <= {6'h00, cfg_wdata_i[1:0]};
				`REG_FALL_EN:    fall_en_q    <= {6'h00, cfg_wdata_i[1:0]};
				default:         diag_interrupt_enable_q    <= diag_interrupt_enable_q;
			endcase
		end
	end

	// process interrupt capture; new edges while pending and not acknowledged count as lost
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			prev_q      <= 2'b00;
			irq_edges_q <= 2'b00;
			irq_state_q <= 2'b00;
			pending_q   <= 1'b0;
			lost_q      <= 1'b0;
		end
		else
		begin
			prev_q <= filt;
			if (|edges && (!pending_q || irq_ack_i))
			begin
				pending_q   <= 1'b1;
				irq_edges_q <= edges;
				irq_state_q <= filt;
			end
			else if (irq_ack_i)
				pending_q <= 1'b0;
			if (|edges && pending_q && !irq_ack_i)
				lost_q <= 1'b1;
			else if (irq_ack_i)
				lost_q <= 1'b0;
		end
	end

	// registered outputs
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			cfg_rdata_o   <= 8'h00;
			input_image_o <= 8'h00;
			proc_irq_o    <= 1'b0;
			diag_irq_o    <= 1'b0;
			irq_lost_o    <= 1'b0;
			run_led_o     <= 1'b0;
			fault_led_o   <= 1'b0;
			ch_led_o      <= 2'b00;
			cfg_error_o   <= 1'b0;
		end
		else
		begin
			input_image_o <= {6'h00, filt};
			ch_led_o      <= filt;
			proc_irq_o    <= pending_q;
			irq_lost_o    <= lost_q;
			diag_irq_o    <= diag_on & lost_q;
			cfg_error_o   <= cfg_err;
			if (!bus_power_ok_i)
			begin
				run_led_o   <= 1'b0;
				fault_led_o <= 1'b0;
			end
			else if (cfg_err)
			begin
				run_led_o   <= blink;
				fault_led_o <= blink;
			end
			else
			begin
				run_led_o   <= bus_ok_i;
				fault_led_o <= !bus_ok_i || module_error_i ||
					(diag_on & lost_q);
			end
			if (cfg_rd_i)
			begin
				case (cfg_addr_i)
					`REG_INPUT_IMAGE: cfg_rdata_o <= {6'h00, filt};
					`REG_DIAG_INTERRUPT_ENABLE:     cfg_rdata_o <= diag_interrupt_enable_q;
					`REG_FILTER_CH0:  cfg_rdata_o <= filter_ch0_q;
					`REG_FILTER_CH1:  cfg_rdata_o <= filter_ch1_q;
					`REG_RISE_EN:     cfg_rdata_o <= rise_en_q;
					`REG_FALL_EN:     cfg_rdata_o <= fall_en_q;
					`REG_IRQ_DATA:    cfg_rdata_o <= {6'h00, irq_edges_q};
					`REG_IRQ_STATE:   cfg_rdata_o <= {6'h00, irq_state_q};
					default:          cfg_rdata_o <= 8'h00;
				endcase
			end
		end
	end
endmodule

/* dual_input_checker.sv */
// port assertions for the dual input module
`timescale 1ns/100ps
module dual_input_checker (
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	input wire logic       bus_ok_i,
	input wire logic       bus_power_ok_i,
	input wire logic       module_error_i,
	input wire logic       cfg_rd_i,
	input wire logic       input_ch0_i,
	input wire logic       irq_ack_i,
	input wire logic [7:0] cfg_rdata_o,
	input wire logic [7:0] input_image_o,
	input wire logic       proc_irq_o,
	input wire logic       run_led_o,
	input wire logic       fault_led_o,
	input wire logic [1:0] ch_led_o,
	input wire logic       cfg_error_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_rsv; input_image_o[7:2] == 6'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("image upper bits set");
	property p_hold; !cfg_rd_i |=> $stable(cfg_rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_chled; ch_led_o == input_image_o[1:0]; endproperty
	a_chled: assert property (p_chled) else $error("channel led wrong");
	// led state trails the inputs one cycle; cfg_error_o shows that cycle's error state
	property p_run; (bus_power_ok_i && bus_ok_i) ##1 !cfg_error_o |-> run_led_o; endproperty
	a_run: assert property (p_run) else $error("run led dark");
	property p_nobus;
		(bus_power_ok_i && !bus_ok_i) ##1 !cfg_error_o |-> !run_led_o && fault_led_o;
	endproperty
	a_nobus: assert property (p_nobus) else $error("no bus leds wrong");
	property p_err;
		(bus_power_ok_i && module_error_i) ##1 !cfg_error_o |-> fault_led_o;
	endproperty
	a_err: assert property (p_err) else $error("fault led dark");
	property p_pwr; !bus_power_ok_i |=> !run_led_o && !fault_led_o; endproperty
	a_pwr: assert property (p_pwr) else $error("leds lit on power fail");
	property p_blink; bus_power_ok_i ##1 cfg_error_o |-> run_led_o == fault_led_o; endproperty
	a_blink: assert property (p_blink) else $error("blink out of step");
	property p_filt; $changed(input_image_o[0]) |-> $past(input_ch0_i, 2) == input_image_o[0];
	endproperty
	a_filt: assert property (p_filt) else $error("image changed early");
	// the output lags the pending flag, so it stays up one cycle after an ack
	property p_irq; proc_irq_o && !irq_ack_i && !$past(irq_ack_i) |=> proc_irq_o; endproperty
	a_irq: assert property (p_irq) else $error("interrupt dropped");
endmodule
bind dual_input_filter_irq_module dual_input_checker chk (.sys_clk_i, .rst_i, .bus_ok_i,
	.bus_power_ok_i, .module_error_i, .cfg_rd_i, .input_ch0_i, .irq_ack_i, .cfg_rdata_o,
	.input_image_o, .proc_irq_o, .run_led_o, .fault_led_o, .ch_led_o, .cfg_error_o);

/* bus_partner_model.sv */
// backplane partner issuing configuration reads and writes
`timescale 1ns/100ps
module bus_partner_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] rdata_i,
	output logic            wr_o = 1'b0,
	output logic            rd_o = 1'b0,
	output logic [2:0]      addr_o = 3'h0,
	output logic [7:0]      wdata_o = 8'h00,
	output logic            stop_o = 1'b0
);
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		stop_o <= (a == 3'h1);
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~v;
		stop_o <= 1'b0;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		#1;
		v = rdata_i;
	endtask
endmodule

/* dual_input_filter_irq_module_bench.sv */
// self-checking bench for the dual input module
`timescale 1ns/100ps
module dual_input_filter_irq_module_bench;
	logic       sys_clk_i = 0, rst_i = 1, ch0 = 0, ch1 = 0, bus_ok = 1, pwr_ok = 1;
	logic       mod_err = 0, out_wr = 0, irq_ack = 0, last;
	logic [7:0] d, out_wdata = 8'hFF;
	wire        cfg_wr, cfg_rd, stop, proc_irq, run_led, fault_led, cfg_err;
	wire        diag_irq, lost;
	wire  [2:0] cfg_addr;
	wire  [7:0] cfg_wdata, cfg_rdata, image;
	wire  [1:0] ch_led;
	int         err_count = 0, tests_run = 0, i;
	bus_partner_model p (.sys_clk_i, .rdata_i(cfg_rdata), .wr_o(cfg_wr), .rd_o(cfg_rd),
		.addr_o(cfg_addr), .wdata_o(cfg_wdata), .stop_o(stop));
	dual_input_filter_irq_module #(.BLINK_HALF(4)) uut (.sys_clk_i, .rst_i, .input_ch0_i(ch0),
		.input_ch1_i(ch1), .bus_ok_i(bus_ok), .bus_power_ok_i(pwr_ok), .module_error_i(mod_err),
		.stop_state_i(stop), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
		.cfg_rd_i(cfg_rd), .out_wr_i(out_wr), .out_wdata_i(out_wdata), .irq_ack_i(irq_ack),
		.cfg_rdata_o(cfg_rdata), .input_image_o(image), .proc_irq_o(proc_irq),
		.diag_irq_o(diag_irq), .irq_lost_o(lost), .run_led_o(run_led),
		.fault_led_o(fault_led), .ch_led_o(ch_led),
		.cfg_error_o(cfg_err));
	initial
	begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task summarize;
		$display("mismatches %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task chk(input logic [7:0] e, s, input string n);
		tests_run++;
		if (s !== e)
		begin
			$display("unexpected %s exp %h got %h", n, e, s);
			err_count++;
		end
	endtask
	task wchk(input logic [7:0] e, s, input string n);
		chk(e, s, n);
		if (s !== e)
			summarize;
	endtask
	task t_cfg;
		logic [7:0] rv [1:5];
		rv = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h00};
		for (int k = 1; k < 6; k++)
		begin
			p.rd(k[2:0], d);
			chk(rv[k], d, "reset value");
		end
		chk(8'h01, {7'h00, run_led}, "run led");
		p.wr(3'h4, 8'hFF);
		p.wr(3'h5, 8'hFF);
		p.wr(3'h1, 8'h40);
		p.wr(3'h2, 8'h00);
		p.rd(3'h4, d);
		chk(8'h03, d, "rise enable");
		p.rd(3'h5, d);
		chk(8'h03, d, "fall enable");
		p.rd(3'h1, d);
		chk(8'h40, d, "diag enable");
	endtask
	task t_filt;
		@(posedge sys_clk_i) ch0 <= 1'b1;
		cyc(50);
		@(posedge sys_clk_i) ch0 <= 1'b0;
		cyc(150);
		chk(8'h00, image, "glitch");
		@(posedge sys_clk_i) ch0 <= 1'b1;
		cyc(95);
		chk(8'h00, image, "early");
		for (i = 0; i < 20 && image !== 8'h01; i++) cyc(1);
		wchk(8'h01, image, "image");
		chk(8'h01, {6'h00, ch_led}, "channel led");
		for (i = 0; i < 8 && proc_irq !== 1'b1; i++) cyc(1);
		wchk(8'h01, {7'h00, proc_irq}, "rise irq");
		p.rd(3'h6, d);
		chk(8'h01, d, "rise edge flags");
		p.rd(3'h7, d);
		chk(8'h01, d, "rise input state");
		@(posedge sys_clk_i) irq_ack <= 1'b1;
		@(posedge sys_clk_i) irq_ack <= 1'b0;
		cyc(1);
		chk(8'h00, {7'h00, proc_irq}, "ack");
		@(posedge sys_clk_i) ch0 <= 1'b0;
		for (i = 0; i < 120 && proc_irq !== 1'b1; i++) cyc(1);
		wchk(8'h01, {7'h00, proc_irq}, "fall irq");
		p.rd(3'h7, d);
		chk(8'h00, d, "fall input state");
		// a new edge while the fall interrupt is still pending is lost
		@(posedge sys_clk_i) ch0 <= 1'b1;
		for (i = 0; i < 120 && lost !== 1'b1; i++) cyc(1);
		wchk(8'h01, {7'h00, lost}, "irq lost");
		chk(8'h01, {7'h00, diag_irq}, "diag irq");
		chk(8'h01, {7'h00, fault_led}, "diag fault led");
		@(posedge sys_clk_i) irq_ack <= 1'b1;
		@(posedge sys_clk_i) irq_ack <= 1'b0;
		cyc(1);
		chk(8'h00, {6'h00, lost, proc_irq}, "lost ack");
	endtask
	task t_leds;
		@(posedge sys_clk_i) out_wr <= 1'b1;
		@(posedge sys_clk_i) out_wr <= 1'b0;
		p.rd(3'h0, d);
		chk(8'h01, d, "image read");
		@(posedge sys_clk_i) mod_err <= 1'b1;
		cyc(3);
		chk(8'h01, {7'h00, fault_led}, "fault led");
		@(posedge sys_clk_i) bus_ok <= 1'b0;
		cyc(3);
		chk(8'h01, {6'h00, run_led, fault_led}, "no bus");
		@(posedge sys_clk_i) pwr_ok <= 1'b0;
		cyc(3);
		chk(8'h00, {6'h00, run_led, fault_led}, "power fail");
		@(posedge sys_clk_i) pwr_ok <= 1'b1;
		bus_ok <= 1'b1;
		mod_err <= 1'b0;
		p.wr(3'h3, 8'h05);
		cyc(3);
		chk(8'h01, {7'h00, cfg_err}, "bad code");
		d = 8'h00;
		last = run_led;
		for (i = 0; i < 20; i++)
		begin
			cyc(1);
			d += (run_led !== last);
			last = run_led;
		end
		chk(8'h01, {7'h00, d > 8'h02}, "blink");
	endtask
	initial
	begin
		cyc(20);
		@(posedge sys_clk_i) rst_i <= 1'b0;
		t_cfg;
		t_filt;
		t_leds;
		summarize;
	end
	initial
	begin
		cyc(20000);
		err_count++;
		summarize;
	end
endmodule
